// ---- bfsi_regs.svh ----
/*
 * Constants of the boot flash sequencer: flash opcodes, address map,
 * configuration page layout and power-up timing.
 * Assumes a 25 MHz system clock and a serial NOR flash that accepts the
 * standard single-bit command set.
 */
`ifndef BFSI_REGS_SVH
`define BFSI_REGS_SVH

// flash opcodes
`define BFSI_OP_WREN      8'h06
`define BFSI_OP_RDSR      8'h05
`define BFSI_OP_READ      8'h03
`define BFSI_OP_QREAD     8'h6B
`define BFSI_OP_ERASE4K   8'h20
`define BFSI_OP_ERASE64K  8'hD8
`define BFSI_OP_PROG      8'h02
`define BFSI_BYTE_IDLE    8'h00

// address map
`define BFSI_OS_TOP          24'h35E000
`define BFSI_FLASH_MIN_BYTES 32'h0040_0000
`define BFSI_FLASH_MAX_BYTES 32'h0100_0000
`define BFSI_CFG_ADDR        24'h001000
`define BFSI_CFG_QUAD_BIT    0
`define BFSI_WIP_BIT         0

// frame layout: opcode plus three address bytes, one dummy for quad read
`define BFSI_HDR_LAST     9'h003
`define BFSI_QHDR_LAST    9'h004
`define BFSI_POLL_LAST    9'h1FF
`define BFSI_BITS_SINGLE  3'h7
`define BFSI_BITS_QUAD    3'h1

// timing
`define BFSI_CLK_HZ          25000000
`define BFSI_POR_HOLD_MS     110
`define BFSI_POR_HOLD_CYCLES (`BFSI_POR_HOLD_MS * (`BFSI_CLK_HZ / 1000))
`define BFSI_SLEEP_HZ        32768
`define BFSI_PWRUP_EDGES     2'h2

`endif

// ---- bfsi_pkg.sv ----
/*
 * Types of the boot flash sequencer: sequencer states and user commands.
 * Assumes bfsi_regs.svh for the numeric constants.
 */
package bfsi_pkg;

	typedef enum logic [6:0] {
		ST_POR  = 7'h01,
		ST_BOOT = 7'h02,
		ST_IDLE = 7'h04,
		ST_WREN = 7'h08,
		ST_XFER = 7'h10,
		ST_POLL = 7'h20,
		ST_GAP  = 7'h40
	} bfsi_state_t;

	typedef enum logic [1:0] {
		CMD_READ     = 2'h0,
		CMD_ERASE4K  = 2'h1,
		CMD_ERASE64K = 2'h2,
		CMD_PROG     = 2'h3
	} bfsi_cmd_t;

endpackage : bfsi_pkg

// ---- bfsi_sync.sv ----
/*
 * Two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level or a clock sampled well above its rate.
 */
module bfsi_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	generate
		if (W < 1) begin : g_chk
			$error("bfsi_sync: W must be at least 1");
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : bfsi_sync

// ---- bfsi_flash_seq.sv ----
/*
 * Boot flash sequencer: power-on hold, single-bit boot read of the
 * configuration page, then read, erase and page-program commands to an
 * external serial NOR flash in SPI mode 0.
 * Assumes flash pins, supply-good levels, the sleep input and the sleep
 * clock arrive asynchronously; user command ports are on clk.
 */
`include "bfsi_regs.svh"

module bfsi_flash_seq import bfsi_pkg::*; #(
	parameter int unsigned FLASH_BYTES     = `BFSI_FLASH_MAX_BYTES,
	parameter int unsigned CLK_DIV         = 2,
	parameter int unsigned POR_HOLD_CYCLES = `BFSI_POR_HOLD_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// power and sleep pins
	input  wire logic        core_supply_ok,
	input  wire logic        io_supply_ok,
	input  wire logic        module_sleep_n,
	input  wire logic        sleep_clock,
	// device status
	output logic             dev_reset,
	output logic             boot_done,
	output logic             quad_mode,
	output logic             sleep_tick,
	// user command port
	input  wire logic        cmd_valid,
	input  wire logic [1:0]  cmd_op,
	input  wire logic [23:0] cmd_addr,
	input  wire logic [7:0]  cmd_len,
	output logic             cmd_ready,
	output logic             cmd_done,
	output logic             cmd_err,
	// program data and read data
	input  wire logic [7:0]  wr_data,
	output logic             wr_take,
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	// flash pins
	output logic             flash_sclk,
	output logic             flash_sclk_oe,
	output logic             flash_cs_n,
	output logic             flash_cs_n_oe,
	output logic [3:0]       flash_io_out,
	output logic [3:0]       flash_io_oe,
	input  wire logic [3:0]  flash_io_in
);

	generate
		if (CLK_DIV < 2 || CLK_DIV > 255) begin : g_div
			$error("bfsi_flash_seq: CLK_DIV must be 2..255");
		end
		if (FLASH_BYTES < `BFSI_FLASH_MIN_BYTES ||
		    FLASH_BYTES > `BFSI_FLASH_MAX_BYTES) begin : g_size
			$error("bfsi_flash_seq: FLASH_BYTES out of range");
		end
		if (POR_HOLD_CYCLES < 1 ||
		    POR_HOLD_CYCLES > `BFSI_POR_HOLD_CYCLES) begin : g_por
			$error("bfsi_flash_seq: POR_HOLD_CYCLES out of range");
		end
	endgenerate

	localparam logic [7:0]  DIV_LAST = 8'(CLK_DIV - 1);
	localparam logic [21:0] POR_LAST = 22'(POR_HOLD_CYCLES - 1);
	localparam logic [24:0] SIZE_LIM = 25'(FLASH_BYTES);

	logic       core_s, io_s, sleep_n_s, slc_s;
	logic [3:0] io_in_s;

	bfsi_sync #(
		.W (8)
	) u_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in ({core_supply_ok, io_supply_ok, module_sleep_n,
		            sleep_clock, flash_io_in}),
		.sync_out ({core_s, io_s, sleep_n_s, slc_s, io_in_s})
	);

	bfsi_state_t state_reg, state_next, ret_reg, ret_next;
	bfsi_cmd_t   kind_reg, kind_next;
	logic [7:0]  div_reg, div_next, op_reg, op_next, sh_reg, sh_next;
	logic [7:0]  len_reg, len_next, rd_data_next;
	logic [2:0]  bit_reg, bit_next;
	logic [8:0]  idx_reg, idx_next, last_reg, last_next;
	logic [23:0] addr_reg, addr_next;
	logic [21:0] por_reg, por_next;
	logic [1:0]  edges_reg, edges_next;
	logic        slc_d_reg, sclk_next, cs_n_next, cs_oe_next;
	logic [3:0]  io_out_next, io_oe_next;
	logic        quad_next, rst_next, boot_next, ready_next, done_next;
	logic        err_next, take_next, rdv_next, tick_next;
	logic        tick, slc_rise, quad_ph, byte_end, start;
	logic [7:0]  rx, start_op, tx;
	logic [8:0]  nidx;

	assign tick     = (div_reg == DIV_LAST);
	assign slc_rise = slc_s & ~slc_d_reg;

	always_comb begin
		state_next   = state_reg;
		ret_next     = ret_reg;
		kind_next    = kind_reg;
		div_next     = tick ? 8'h00 : div_reg + 8'h01;
		op_next      = op_reg;
		sh_next      = sh_reg;
		len_next     = len_reg;
		bit_next     = bit_reg;
		idx_next     = idx_reg;
		last_next    = last_reg;
		addr_next    = addr_reg;
		por_next     = por_reg;
		edges_next   = edges_reg;
		sclk_next    = flash_sclk;
		cs_n_next    = flash_cs_n;
		quad_next    = quad_mode;
		rst_next     = dev_reset;
		boot_next    = boot_done;
		done_next    = 1'b0;
		err_next     = 1'b0;
		take_next    = 1'b0;
		rdv_next     = 1'b0;
		rd_data_next = rd_data;
		start        = 1'b0;
		start_op     = `BFSI_BYTE_IDLE;
		tx           = `BFSI_BYTE_IDLE;
		nidx         = idx_reg + 9'h001;
		tick_next    = slc_rise;
		quad_ph      = quad_mode && state_reg == ST_XFER &&
		               kind_reg == CMD_READ && idx_reg > `BFSI_QHDR_LAST;
		rx           = quad_ph ? {sh_reg[3:0], io_in_s} :
		                         {sh_reg[6:0], io_in_s[1]};
		byte_end     = 1'b0;

		// next byte to send: opcode, then address MSB first
		case (nidx)
			9'h001:  tx = addr_reg[23:16];
			9'h002:  tx = addr_reg[15:8];
			9'h003:  tx = addr_reg[7:0];
			default: tx = (state_reg == ST_XFER && kind_reg == CMD_PROG) ?
			              wr_data : `BFSI_BYTE_IDLE;
		endcase

		// bit engine: rise lets flash sample, fall samples and shifts
		if (tick && !flash_cs_n && state_reg != ST_GAP) begin
			sclk_next = ~flash_sclk;
			if (flash_sclk) begin
				sh_next  = rx;
				bit_next = bit_reg - 3'h1;
				byte_end = (bit_reg == 3'h0);
			end
		end

		case (state_reg)
			ST_POR: begin
				rst_next = 1'b1;
				if (!(core_s && io_s)) begin
					por_next   = 22'h0;
					edges_next = 2'h0;
				end else begin
					if (slc_rise && edges_reg != `BFSI_PWRUP_EDGES)
						edges_next = edges_reg + 2'h1;
					if (por_reg != POR_LAST)
						por_next = por_reg + 22'h1;
					else if (edges_reg == `BFSI_PWRUP_EDGES && tick) begin
						rst_next   = 1'b0;
						addr_next  = `BFSI_CFG_ADDR;
						last_next  = `BFSI_QHDR_LAST;
						start      = 1'b1;
						start_op   = `BFSI_OP_READ;
						state_next = ST_BOOT;
					end
				end
			end
			ST_BOOT: begin
				if (byte_end && idx_reg == `BFSI_QHDR_LAST)
					quad_next = rx[`BFSI_CFG_QUAD_BIT];
			end
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					kind_next = bfsi_cmd_t'(cmd_op);
					addr_next = cmd_addr;
					len_next  = cmd_len;
					if ({1'b0, cmd_addr} >= SIZE_LIM)
						err_next = 1'b1;
					else if (cmd_op != CMD_READ && cmd_addr < `BFSI_OS_TOP)
						err_next = 1'b1;
					else if (cmd_op == CMD_READ) begin
						start      = 1'b1;
						state_next = ST_XFER;
						if (quad_mode) begin
							start_op  = `BFSI_OP_QREAD;
							last_next = `BFSI_QHDR_LAST + {1'b0, cmd_len} + 9'h001;
						end else begin
							start_op  = `BFSI_OP_READ;
							last_next = `BFSI_HDR_LAST + {1'b0, cmd_len} + 9'h001;
						end
					end else begin
						start      = 1'b1;
						start_op   = `BFSI_OP_WREN;
						last_next  = 9'h000;
						state_next = ST_WREN;
					end
				end
			end
			ST_XFER: begin
				if (byte_end && kind_reg == CMD_READ &&
				    idx_reg > (quad_mode ? `BFSI_QHDR_LAST : `BFSI_HDR_LAST)) begin
					rdv_next     = 1'b1;
					rd_data_next = rx;
				end
			end
			ST_GAP: begin
				if (tick) begin
					case (ret_reg)
						ST_BOOT: begin
							boot_next  = 1'b1;
							state_next = ST_IDLE;
						end
						ST_WREN: begin
							start      = 1'b1;
							state_next = ST_XFER;
							case (kind_reg)
								CMD_ERASE4K: start_op = `BFSI_OP_ERASE4K;
								CMD_ERASE64K: start_op = `BFSI_OP_ERASE64K;
								default: start_op = `BFSI_OP_PROG;
							endcase
							last_next = (kind_reg == CMD_PROG) ?
							            `BFSI_HDR_LAST + {1'b0, len_reg} + 9'h001 :
							            `BFSI_HDR_LAST;
						end
						ST_XFER: begin
							if (kind_reg == CMD_READ) begin
								done_next  = 1'b1;
								state_next = ST_IDLE;
							end else begin
								start      = 1'b1;
								start_op   = `BFSI_OP_RDSR;
								last_next  = `BFSI_POLL_LAST;
								state_next = ST_POLL;
							end
						end
						default: begin
							done_next  = 1'b1;
							state_next = ST_IDLE;
						end
					endcase
				end
			end
			default: ;
		endcase

		// byte boundary: end frame or load next byte
		if (byte_end) begin
			if ((idx_reg == last_reg && state_reg != ST_POLL) ||
			    (state_reg == ST_POLL && idx_reg != 9'h000 &&
			     !rx[`BFSI_WIP_BIT])) begin
				cs_n_next  = 1'b1;
				ret_next   = state_reg;
				state_next = ST_GAP;
			end else begin
				idx_next = nidx;
				sh_next  = tx;
				take_next = (state_reg == ST_XFER && kind_reg == CMD_PROG &&
				             nidx > `BFSI_HDR_LAST);
				bit_next = (quad_mode && state_reg == ST_XFER &&
				            kind_reg == CMD_READ && nidx > `BFSI_QHDR_LAST) ?
				           `BFSI_BITS_QUAD : `BFSI_BITS_SINGLE;
			end
		end

		if (start) begin
			op_next   = start_op;
			sh_next   = start_op;
			idx_next  = 9'h000;
			bit_next  = `BFSI_BITS_SINGLE;
			sclk_next = 1'b0;
			cs_n_next = 1'b0;
		end

		// single-bit after reset, release pins while asleep
		if (!sleep_n_s) begin
			state_next = ST_POR;
			cs_n_next  = 1'b1;
			sclk_next  = 1'b0;
			quad_next  = 1'b0;
			rst_next   = 1'b1;
			boot_next  = 1'b0;
			por_next   = 22'h0;
			edges_next = 2'h0;
		end

		// io0 carries data, io2/io3 held high as WP/HOLD in single phases
		io_out_next = {2'b11, 1'b0, sh_next[7]};
		io_oe_next  = (sleep_n_s && !(quad_mode && state_next == ST_XFER &&
		              kind_next == CMD_READ && idx_next > `BFSI_QHDR_LAST)) ?
		              4'hD : 4'h0;
		cs_oe_next  = sleep_n_s;
		ready_next  = (state_next == ST_IDLE) && !start;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg     <= ST_POR;
			ret_reg       <= ST_POR;
			kind_reg      <= CMD_READ;
			div_reg       <= 8'h00;
			op_reg        <= `BFSI_BYTE_IDLE;
			sh_reg        <= `BFSI_BYTE_IDLE;
			len_reg       <= 8'h00;
			bit_reg       <= `BFSI_BITS_SINGLE;
			idx_reg       <= 9'h000;
			last_reg      <= 9'h000;
			addr_reg      <= 24'h000000;
			por_reg       <= 22'h0;
			edges_reg     <= 2'h0;
			slc_d_reg     <= 1'b0;
			flash_sclk    <= 1'b0;
			flash_sclk_oe <= 1'b0;
			flash_cs_n    <= 1'b1;
			flash_cs_n_oe <= 1'b0;
			flash_io_out  <= 4'h0;
			flash_io_oe   <= 4'h0;
			quad_mode     <= 1'b0;
			dev_reset     <= 1'b1;
			boot_done     <= 1'b0;
			cmd_ready     <= 1'b0;
			cmd_done      <= 1'b0;
			cmd_err       <= 1'b0;
			wr_take       <= 1'b0;
			rd_valid      <= 1'b0;
			rd_data       <= 8'h00;
			sleep_tick    <= 1'b0;
		end else begin
			state_reg     <= state_next;
			ret_reg       <= ret_next;
			kind_reg      <= kind_next;
			div_reg       <= div_next;
			op_reg        <= op_next;
			sh_reg        <= sh_next;
			len_reg       <= len_next;
			bit_reg       <= bit_next;
			idx_reg       <= idx_next;
			last_reg      <= last_next;
			addr_reg      <= addr_next;
			por_reg       <= por_next;
			edges_reg     <= edges_next;
			slc_d_reg     <= slc_s;
			flash_sclk    <= sclk_next;
			flash_sclk_oe <= cs_oe_next;
			flash_cs_n    <= cs_n_next;
			flash_cs_n_oe <= cs_oe_next;
			flash_io_out  <= io_out_next;
			flash_io_oe   <= io_oe_next;
			quad_mode     <= quad_next;
			dev_reset     <= rst_next;
			boot_done     <= boot_next;
			cmd_ready     <= ready_next;
			cmd_done      <= done_next;
			cmd_err       <= err_next;
			wr_take       <= take_next;
			rd_valid      <= rdv_next;
			rd_data       <= rd_data_next;
			sleep_tick    <= tick_next;
		end
	end

endmodule : bfsi_flash_seq

// ---- bfsi_flash_seq_props.sv ----
/* checker on the ports of the boot flash sequencer.
   assumes one clk domain and a synchronous active high srst. */
module bfsi_flash_seq_props import bfsi_pkg::*; #(
	parameter int unsigned FLASH_BYTES     = 32'h0100_0000,
	parameter int unsigned POR_HOLD_CYCLES = 20
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// power, sleep and status
	input wire logic        core_supply_ok,
	input wire logic        io_supply_ok,
	input wire logic        module_sleep_n,
	input wire logic        sleep_clock,
	input wire logic        dev_reset,
	input wire logic        boot_done,
	input wire logic        quad_mode,
	input wire logic        sleep_tick,
	// command port
	input wire logic        cmd_valid,
	input wire logic [1:0]  cmd_op,
	input wire logic [23:0] cmd_addr,
	input wire logic        cmd_ready,
	input wire logic        cmd_err,
	// flash pins
	input wire logic        flash_cs_n,
	input wire logic        flash_cs_n_oe,
	input wire logic        flash_sclk_oe,
	input wire logic [3:0]  flash_io_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] por_cnt_reg;
	logic [31:0] por_cnt_next;
	logic        addr_ok;
	assign addr_ok = {8'h00, cmd_addr} < FLASH_BYTES;
	// cycles spent in reset while awake with both supplies good
	always_comb begin
		por_cnt_next = 32'h0;
		if (dev_reset && core_supply_ok && io_supply_ok && module_sleep_n)
			por_cnt_next = por_cnt_reg + 32'h1;
	end
	always_ff @(posedge clk) begin
		if (srst)
			por_cnt_reg <= 32'h0;
		else
			por_cnt_reg <= por_cnt_next;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence take_s;
		cmd_valid && cmd_ready;
	endsequence
	sequence asleep_s;
		!module_sleep_n [*4];
	endsequence
	a_refuse_low: assert property (
		take_s ##0 (cmd_op != CMD_READ && cmd_addr < 24'h35E000)
		|-> ##1 cmd_err) else $error("protected write accepted");
	a_refuse_top: assert property (
		take_s ##0 !addr_ok |-> ##1 cmd_err)
		else $error("address past flash accepted");
	a_accept_ok: assert property (
		take_s ##0 (addr_ok && (cmd_op == CMD_READ
		|| cmd_addr >= 24'h35E000)) |->
		##1 (!cmd_ready && !cmd_err) ##1 !cmd_err)
		else $error("user space command refused");
	a_sleep_free: assert property (
		asleep_s |-> !flash_cs_n_oe && !flash_sclk_oe &&
		flash_io_oe == 4'h0)
		else $error("flash pins driven while asleep");
	a_reset_single: assert property (disable iff (1'b0)
		srst |=> !quad_mode && flash_cs_n && !cmd_ready)
		else $error("reset left quad or frame");
	a_quad_steady: assert property (
		boot_done && cmd_ready && $past(cmd_ready) |-> $stable(quad_mode))
		else $error("quad changed outside boot");
	a_por_bound: assert property (
		por_cnt_reg <= POR_HOLD_CYCLES + 64)
		else $error("device reset held too long");
	a_tick_follow: assert property (disable iff (srst || !module_sleep_n)
		$rose(sleep_clock) |-> ##[1:4] sleep_tick)
		else $error("sleep clock edge missed");
	a_tick_pulse: assert property (
		sleep_tick |=> !sleep_tick) else $error("sleep tick too long");
	a_idle_cs: assert property (
		cmd_ready && flash_cs_n_oe |-> flash_cs_n)
		else $error("chip select low while idle");
endmodule : bfsi_flash_seq_props

bind bfsi_flash_seq bfsi_flash_seq_props #(
	.FLASH_BYTES(FLASH_BYTES),
	.POR_HOLD_CYCLES(POR_HOLD_CYCLES)
) u_props (.clk, .srst, .core_supply_ok, .io_supply_ok, .module_sleep_n,
	.sleep_clock, .dev_reset, .boot_done, .quad_mode, .sleep_tick,
	.cmd_valid, .cmd_op, .cmd_addr, .cmd_ready, .cmd_err, .flash_cs_n,
	.flash_cs_n_oe, .flash_sclk_oe, .flash_io_oe);

// ---- bfsi_flash_model.sv ----
/* serial NOR flash, single-bit commands with quad read output, SPI mode 0, behavioural.
   assumes chip select is high whenever no master drives it. */
module bfsi_flash_model (
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic     miso,
	output logic     qon,
	output logic [3:0] qout,
	// image setting
	input wire logic quad_en
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  sh;
	logic [7:0]  op;
	logic [7:0]  t;
	logic [7:0]  ops[$];
	logic [7:0]  pdat[$];
	logic [23:0] adr;
	int          cnt;
	int          wip;
	initial miso = 1'b0;
	initial qon = 1'b0;
	initial qout = 4'h0;
	initial wip = 0;
	function automatic logic [7:0] ob(input int b);
		logic [23:0] a2;
		a2 = adr + 24'(b - 4);
		if (op == 8'h05)
			return {7'h00, wip != 0};
		if (b < 4)
			return 8'h00;
		if (adr == 24'h001000)
			return {7'h00, quad_en};
		return a2[7:0] ^ a2[15:8] ^ 8'h5A;
	endfunction : ob
	always @(negedge cs_n) cnt = 0;
	always @(posedge cs_n) begin
		miso = ~miso;
		qon = 1'b0;
		if (cnt >= 32 && (op == 8'h20 || op == 8'hD8 || op == 8'h02))
			wip = 2;
	end
	always @(posedge sclk) if (!cs_n) begin
		sh = {sh[6:0], mosi};
		cnt++;
		if (cnt % 8 == 0) begin
			if (cnt == 8) begin
				op = sh;
				ops.push_back(sh);
			end else if (cnt <= 32 && op != 8'h05)
				adr = {adr[15:0], sh};
			else if (op == 8'h02)
				pdat.push_back(sh);
			if (op == 8'h05 && wip > 0)
				wip--;
		end
	end
	always @(negedge sclk) if (!cs_n) begin
		t = ob(cnt / 8);
		miso = t[7 - cnt % 8];
		// quad read: one nibble per clock after the dummy byte, high first
		qon = (op == 8'h6B && cnt >= 40);
		t = ob(4 + (cnt - 40) / 2);
		qout = cnt[0] ? t[3:0] : t[7:4];
	end
endmodule : bfsi_flash_model

// ---- bfsi_flash_seq_bench.sv ----
/* self-checking bench of the boot flash sequencer.
   assumes the checker binds itself and the flash model stands outside. */
module bfsi_flash_seq_bench import bfsi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned FB = 32'h0040_0000;
	logic clk, srst, core_supply_ok, io_supply_ok, module_sleep_n;
	logic sleep_clock, dev_reset, boot_done, quad_mode, sleep_tick;
	logic cmd_valid, cmd_ready, cmd_done, cmd_err, wr_take, rd_valid;
	logic flash_sclk, flash_cs_n, flash_cs_n_oe, miso, cs_w, cfg_quad, ef;
	logic flash_sclk_oe, qon;
	logic [1:0] cmd_op;
	logic [23:0] cmd_addr;
	logic [7:0] cmd_len, wr_data, rd_data, rq[$], pq[$];
	logic [3:0] flash_io_out, flash_io_oe, flash_io_in, qout;
	int err_total = 0;
	int compares = 0;
	assign cs_w = flash_cs_n_oe ? flash_cs_n : 1'b1;
	assign flash_io_in = (flash_io_oe & flash_io_out) | (~flash_io_oe
		& (qon ? qout : {~flash_io_out[3:2], miso, ~flash_io_out[0]}));
	bfsi_flash_seq #(.FLASH_BYTES(FB), .CLK_DIV(2), .POR_HOLD_CYCLES(20))
		dut (.clk, .srst, .core_supply_ok, .io_supply_ok, .module_sleep_n,
		.sleep_clock, .dev_reset, .boot_done, .quad_mode, .sleep_tick,
		.cmd_valid, .cmd_op, .cmd_addr, .cmd_len, .cmd_ready, .cmd_done,
		.cmd_err, .wr_data, .wr_take, .rd_valid, .rd_data, .flash_sclk,
		.flash_sclk_oe, .flash_cs_n, .flash_cs_n_oe, .flash_io_out,
		.flash_io_oe, .flash_io_in);
	bfsi_flash_model fl (.sclk(flash_sclk & flash_sclk_oe), .cs_n(cs_w),
		.mosi(flash_io_in[0]), .miso(miso), .qon(qon), .qout(qout),
		.quad_en(cfg_quad));
	function automatic logic [7:0] fd(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : fd
	function automatic logic [7:0] xop(input bfsi_cmd_t c);
		case (c)
			CMD_ERASE4K: return 8'h20;
			CMD_ERASE64K: return 8'hD8;
			default: return 8'h02;
		endcase
	endfunction : xop
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic hang();
		err_total++;
		close_out();
	endtask : hang
	task automatic wait_ready();
		int n;
		for (n = 0; n < 4000 && cmd_ready !== 1'b1; n++)
			@(negedge clk);
		if (n == 4000)
			hang();
	endtask : wait_ready
	task automatic run(input bfsi_cmd_t op, input logic [23:0] a,
		input logic [7:0] len);
		int n;
		int i;
		wait_ready();
		rq.delete();
		pq.delete();
		fl.ops.delete();
		fl.pdat.delete();
		for (i = 0; i <= len; i++)
			pq.push_back(8'($urandom));
		i = 0;
		ef = 1'b0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_len <= len;
		wr_data <= pq[0];
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (n = 0; n < 4000; n++) begin
			@(negedge clk);
			if (rd_valid === 1'b1)
				rq.push_back(rd_data);
			if (cmd_err === 1'b1)
				ef = 1'b1;
			if (cmd_done === 1'b1 || ef)
				break;
			if (wr_take === 1'b1) begin
				i++;
				@(posedge clk);
				wr_data <= pq[i % pq.size()];
			end
		end
		if (n == 4000)
			hang();
	endtask : run
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		sleep_clock = 1'b0;
		#7;
		forever #160 sleep_clock = ~sleep_clock;
	end
	initial begin
		logic [23:0] a;
		logic [7:0]  ln;
		bfsi_cmd_t   op;
		int          k;
		srst = 1'b1;
		core_supply_ok = 1'b1;
		io_supply_ok = 1'b1;
		module_sleep_n = 1'b1;
		cfg_quad = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_addr = 24'h000000;
		cmd_len = 8'h00;
		wr_data = 8'h00;
		void'($urandom(62));
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		wait_ready();
		chk(fl.ops[0], 8'h03);
		chk(fl.adr, 24'h001000);
		chk({boot_done, quad_mode}, 2'h2);
		for (k = 0; k < 6; k++) begin
			a = 24'h35E000 + 24'($urandom % 32'h000A_1FF0);
			ln = 8'($urandom % 4);
			if (k == 0) begin
				a = 24'(FB - 1);
				ln = 8'h00;
			end
			run(CMD_READ, a, ln);
			chk(rq.size(), ln + 1);
			foreach (rq[j]) chk(rq[j], fd(a + 24'(j)));
		end
		for (k = 0; k < 3; k++) begin
			op = bfsi_cmd_t'(k + 1);
			a = 24'h35E000 + 24'((k == 0) ? 0 : $urandom % 32'h000A_0000);
			run(op, a, 8'($urandom % 4));
			chk({fl.ops[0], fl.ops[1], fl.ops[2]}, {8'h06, xop(op), 8'h05});
			chk({ef, fl.adr}, {1'b0, a});
			chk(fl.wip, 0);
			if (op == CMD_PROG)
				foreach (pq[j]) chk(fl.pdat[j], pq[j]);
		end
		run(CMD_ERASE4K, 24'h35DFFF, 8'h00);
		chk({ef, 8'(fl.ops.size())}, 9'h100);
		run(CMD_READ, 24'(FB), 8'h00);
		chk({ef, 8'(fl.ops.size())}, 9'h100);
		@(posedge clk);
		module_sleep_n <= 1'b0;
		cfg_quad <= 1'b1;
		repeat (6) @(negedge clk);
		chk({flash_cs_n_oe, flash_sclk_oe, flash_io_oe, quad_mode}, 7'h00);
		fl.ops.delete();
		@(posedge clk);
		module_sleep_n <= 1'b1;
		repeat (4) @(negedge clk);
		wait_ready();
		chk({fl.ops[0], quad_mode}, 9'h007);
		a = 24'h35E000 + 24'($urandom % 32'h000A_1FF0);
		run(CMD_READ, a, 8'h03);
		chk({fl.ops[0], 8'(rq.size())}, 16'h6B04);
		foreach (rq[j]) chk(rq[j], fd(a + 24'(j)));
		@(posedge clk);
		srst <= 1'b1;
		io_supply_ok <= 1'b0;
		fl.ops.delete();
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk(quad_mode, 1'b0);
		repeat (10) @(posedge clk);
		io_supply_ok <= 1'b1;
		wait_ready();
		chk({fl.ops[0], quad_mode}, 9'h007);
		close_out();
	end
endmodule : bfsi_flash_seq_bench
